// File: core/lane_signal_interlock.sv
// lane control signal: face decode, face and group interlock, monitor code, backup emitters
// assumes pins asynchronous to clk_sys (20 MHz) and peers joined on the interlock chain
`include "lane_signal_regs.svh"

// Functional notes
// RULE1: never light forward and rearward arrows together; block such requests.
// RULE2: arrow lit only while whole group shows cross on the reverse face.
// RULE3: group decision uses only the interlock chain, nothing supervisory.
// RULE4: chain works for one up to thirty members.
// RULE5: a failed lit cross withdraws group permit, removing reverse arrows everywhere.
// RULE6: interlock fault removes arrows and keeps requested crosses lit.
// RULE7: momentary interlock faults are latched and keep arrows off.
// RULE8: the fault latch clears only when the drive code changes.
// RULE9: other permitted aspects stay selectable while arrows are blocked.
// RULE10: cross of a blocked cross-plus-arrow request lights at once.
// RULE11: deferred arrow lights when permitted if the request is unchanged.
// RULE12: monitor code reports the face actually lit.
// RULE13: arrows removed by interlock never raise lamp failure.
// RULE14: bypass link passes the chain straight through.
// RULE15: switch to backup emitter well within half a second.
// RULE16: four drive inputs select one face combination.
// RULE17: four monitor outputs derived from sensed lamp state.
// RULE18: after reset nothing lit, then follow drive code.
// RULE19: arrow never lit without a lit cross on the reverse face.
// RULE20: drive and interlock inputs synchronised and debounced; change by compare. The health line is only synchronised, not debounced.
// RULE21: face code table is a parameter.
module lane_signal_interlock import lane_signal_pkg::*; #(
   parameter aspect_t [15:0] FACE_MAP = FACE_MAP_DEF,
   parameter int MAX_MEMBERS = `MAX_GROUP_MEMBERS,
   parameter int DEB_CYCLES = (`DEB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int DEGRADE_CYCLES = (`DEGRADE_TIME_MS * 1000000) / `CLK_PERIOD_NS
)(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [3:0] drive_code,
   input wire logic [3:0] lamp_ok,
   input wire logic [3:0] primary_ok,
   input wire logic ilk_bypass,
   input wire ilk_in_t ilk_in,
   output ilk_out_t ilk_out,
   output aspect_t lamp_drive,
   output logic [3:0] backup_sel,
   output logic [3:0] mon_code,
   output logic [3:0] lamp_fail,
   output logic ilk_fault,
   output logic ilk_latched
);
   localparam int SETTLE = DEB_CYCLES + 4;
   localparam int SW = $clog2(SETTLE + 1);

   if (MAX_MEMBERS < 1 || MAX_MEMBERS > `MAX_GROUP_MEMBERS) begin : g_bad_members
      $error("member count out of range");
   end
   if (SETTLE + 2 >= DEGRADE_CYCLES) begin : g_bad_degrade
      $error("debounce too slow for emitter switchover");
   end

   function automatic logic [3:0] code_of(input aspect_t lit);
      logic [3:0] c;
      c = `FACE_UNKNOWN;
      for (int i = 15; i >= 0; i--) begin
         if (FACE_MAP[i] == lit) c = 4'(i);
      end
      return c;
   endfunction : code_of

   // synchronised and filtered pins
   logic [3:0] code_s, lamp_ok_s, prim_s;
   logic [1:0] perm_s, grp_s;
   logic bypass_s, health_s, code_valid;

   input_debounce #(.W(17), .STABLE(DEB_CYCLES)) u_deb ( // RULE20
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pin({ilk_bypass, ilk_in.grp, ilk_in.perm, primary_ok, lamp_ok, drive_code}),
      .value({bypass_s, grp_s, perm_s, prim_s, lamp_ok_s, code_s}),
      .valid(code_valid)
   );

   // health is only synchronised, not filtered, so that a one-cycle drop is still seen;
   // reset to the intact level so that no false fault follows reset
   logic health_s1_ff, health_s2_ff;
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         health_s1_ff <= 1'b1;
         health_s2_ff <= 1'b1;
      end else begin
         health_s1_ff <= ilk_in.health;
         health_s2_ff <= health_s1_ff;
      end
   end
   assign health_s = health_s2_ff; // RULE20

   ilk_state_t state_ff, nxt_state;
   aspect_t drive_ff, nxt_drive, req, lit;
   logic [3:0] code_prev_ff, mon_ff, nxt_mon, fail_ff, nxt_fail, bk_ff, nxt_bk;
   logic [1:0] pout_ff, nxt_pout;
   logic hout_ff, nxt_hout, fault_ff, nxt_fault;
   logic code_chg, fault, allow_f, allow_r, dual;
   logic [3:0] settled;

   assign req = FACE_MAP[code_s]; // RULE16 RULE21
   assign lit = drive_ff & lamp_ok_s; // RULE17
   assign code_chg = code_s != code_prev_ff; // RULE20
   assign fault = !health_s; // RULE6 RULE7
   assign dual = req.fwd_arrow && req.rev_arrow;

   // arrow permits come from the chain and the own lit cross
   assign allow_f = grp_s[0] && lit.rev_cross && !fault && !dual; // RULE1 RULE2 RULE3 RULE19
   assign allow_r = grp_s[1] && lit.fwd_cross && !fault && !dual; // RULE1 RULE2 RULE3 RULE19

   always_comb begin
      nxt_state = state_ff;
      nxt_drive = '0;
      case (state_ff)
         ST_BLANK: begin
            if (code_valid) nxt_state = ST_RUN; // RULE18
         end
         ST_RUN: begin
            if (fault) nxt_state = ST_LATCHED; // RULE7
         end
         ST_LATCHED: begin
            if (code_chg && !fault) nxt_state = ST_RUN; // RULE8
         end
         default: nxt_state = ST_BLANK;
      endcase
      if (state_ff != ST_BLANK) begin
         nxt_drive.fwd_cross = req.fwd_cross; // RULE6 RULE9 RULE10
         nxt_drive.rev_cross = req.rev_cross; // RULE6 RULE9 RULE10
         if (state_ff == ST_RUN && !fault) begin
            nxt_drive.fwd_arrow = req.fwd_arrow && allow_f; // RULE11
            nxt_drive.rev_arrow = req.rev_arrow && allow_r; // RULE11
         end
      end
   end

   // chain outputs: own lit cross joins the permit, bypass links through
   always_comb begin
      if (bypass_s) begin
         nxt_pout = perm_s; // RULE14
      end else begin
         nxt_pout[0] = perm_s[0] && lit.rev_cross; // RULE4 RULE5
         nxt_pout[1] = perm_s[1] && lit.fwd_cross; // RULE4 RULE5
      end
      nxt_hout = health_s;
      nxt_fault = fault;
      nxt_mon = code_of(lit); // RULE12
   end

   // per aspect: failure report and backup switchover once drive has settled
   generate
      for (genvar g = 0; g < 4; g++) begin : g_asp
         logic [SW-1:0] on_cnt_ff, nxt_on_cnt;
         always_comb begin
            nxt_on_cnt = on_cnt_ff;
            if (!drive_ff[g]) begin
               nxt_on_cnt = '0;
            end else if (on_cnt_ff < SW'(SETTLE)) begin
               nxt_on_cnt = on_cnt_ff + SW'(1);
            end
         end
         always_ff @(posedge clk_sys) begin
            if (!resetn) begin
               on_cnt_ff <= '0;
            end else begin
               on_cnt_ff <= nxt_on_cnt;
            end
         end
         assign settled[g] = on_cnt_ff == SW'(SETTLE);
         assign nxt_fail[g] = settled[g] && drive_ff[g] && !lamp_ok_s[g]; // RULE13
         assign nxt_bk[g] = bk_ff[g] || (settled[g] && !prim_s[g]); // RULE15
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state_ff <= ST_BLANK;
         drive_ff <= '0;
         code_prev_ff <= 4'h0;
         mon_ff <= `FACE_UNKNOWN;
         fail_ff <= 4'h0;
         bk_ff <= 4'h0;
         pout_ff <= 2'h0;
         hout_ff <= 1'b0;
         fault_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         drive_ff <= nxt_drive;
         code_prev_ff <= code_s;
         mon_ff <= nxt_mon;
         fail_ff <= nxt_fail;
         bk_ff <= nxt_bk;
         pout_ff <= nxt_pout;
         hout_ff <= nxt_hout;
         fault_ff <= nxt_fault;
      end
   end

   assign lamp_drive = drive_ff;
   assign backup_sel = bk_ff;
   assign mon_code = mon_ff;
   assign lamp_fail = fail_ff;
   assign ilk_out.perm = pout_ff;
   assign ilk_out.health = hout_ff;
   assign ilk_fault = fault_ff;
   assign ilk_latched = state_ff[2];

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   chk_no_dual_arrow: assert property (!(drive_ff.fwd_arrow && drive_ff.rev_arrow)) // RULE1
      else $error("both arrows lit");
   chk_arrow_group_ok: assert property (nxt_drive.fwd_arrow |-> grp_s[0] && lit.rev_cross) // RULE2
      else $error("forward arrow without group permit");
   chk_fault_kills: assert property (fault |=> !drive_ff.fwd_arrow && !drive_ff.rev_arrow && ilk_fault) // RULE6
      else $error("arrow survives interlock fault");
   chk_fault_cross: assert property (fault && state_ff != ST_BLANK && req.fwd_cross |=> drive_ff.fwd_cross) // RULE6
      else $error("cross dropped on fault");
   chk_latch_hold: assert property (state_ff == ST_LATCHED && !code_chg |=> ilk_latched && !drive_ff.fwd_arrow) // RULE7
      else $error("latch released without code change");
   chk_latch_clear: assert property (state_ff == ST_LATCHED && code_chg && !fault |=> !ilk_latched) // RULE8
      else $error("latch not cleared by code change");
   chk_cross_now: assert property (state_ff == ST_RUN && req.fwd_cross && req.rev_arrow && !allow_r
      |=> drive_ff.fwd_cross && !drive_ff.rev_arrow) // RULE10
      else $error("cross delayed by blocked arrow");
   chk_cross_fail_perm: assert property (!bypass_s && drive_ff.rev_cross && !lamp_ok_s[`ASP_REV_CROSS]
      |=> !ilk_out.perm[0]) // RULE5
      else $error("failed cross keeps group permit");
   chk_no_fail_block: assert property (!drive_ff.fwd_arrow |=> !lamp_fail[`ASP_FWD_ARROW]) // RULE13
      else $error("blocked arrow reported as failure");
   chk_bypass_pass: assert property (bypass_s |=> ilk_out.perm == $past(perm_s)) // RULE14
      else $error("bypass does not link through");
   chk_blank_start: assert property (state_ff == ST_BLANK |=> lamp_drive == '0) // RULE18
      else $error("aspect lit before start");
   chk_mon_blank: assert property (lamp_drive == '0 ##1 lamp_drive == '0 |=> mon_code == code_of('0)) // RULE12
      else $error("monitor code wrong while dark");

   cov_arrow_lit: cover property (drive_ff.fwd_arrow);
   cov_deferred: cover property (req.rev_arrow && !drive_ff.rev_arrow ##[1:100] drive_ff.rev_arrow);
   cov_latched: cover property (state_ff == ST_LATCHED ##[1:100] state_ff == ST_RUN);
   cov_backup: cover property ($rose(bk_ff[`ASP_FWD_CROSS]));
endmodule : lane_signal_interlock

// File: core/lane_signal_regs.svh
// timing counts, limits and codes for the lane signal interlock
// assumes a single 20 MHz system clock
`ifndef LANE_SIGNAL_REGS_SVH
`define LANE_SIGNAL_REGS_SVH
`define CLK_PERIOD_NS 50
`define DEB_TIME_NS 1000
`define DEGRADE_TIME_MS 500
`define MAX_GROUP_MEMBERS 30
`define FACE_UNKNOWN 4'hF
`define ASP_FWD_CROSS 0
`define ASP_FWD_ARROW 1
`define ASP_REV_CROSS 2
`define ASP_REV_ARROW 3
`endif

// File: core/lane_signal_pkg.sv
// types for the lane signal interlock
// assumes lane_signal_regs.svh for numeric constants
package lane_signal_pkg;
   typedef struct packed {
      logic rev_arrow;
      logic rev_cross;
      logic fwd_arrow;
      logic fwd_cross;
   } aspect_t;

   // chain: perm is daisy-chained, grp is the chain end returned to all members
   typedef struct packed {
      logic [1:0] perm;
      logic [1:0] grp;
      logic health;
   } ilk_in_t;

   typedef struct packed {
      logic [1:0] perm;
      logic health;
   } ilk_out_t;

   typedef enum logic [2:0] {
      ST_BLANK = 3'b001,
      ST_RUN = 3'b010,
      ST_LATCHED = 3'b100
   } ilk_state_t;

   // default face table: 0 blank, 1 fwd cross, 2 fwd arrow + rev cross,
   // 3 rev cross, 4 rev arrow + fwd cross, 5 both crosses, rest blank
   localparam aspect_t [15:0] FACE_MAP_DEF = {
      {10{4'h0}}, 4'h5, 4'h9, 4'h4, 4'h6, 4'h1, 4'h0};
endpackage : lane_signal_pkg

// File: core/input_debounce.sv
// two-flop synchroniser plus stability filter for a group of pin inputs
// assumes pins are asynchronous to clk_sys
module input_debounce #(
   parameter int W = 1,
   parameter int STABLE = 1
)(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] value,
   output logic valid
);
   localparam int CW = $clog2(STABLE + 1);
   localparam logic [CW-1:0] CMAX = CW'(STABLE);
   logic [W-1:0] sync1_ff, sync2_ff, stable_ff, nxt_stable, last_ff;
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic valid_ff, nxt_valid;

   if (W < 1 || STABLE < 1) begin : g_bad_param
      $error("input_debounce: bad parameters");
   end

   always_comb begin
      nxt_stable = stable_ff;
      nxt_valid = valid_ff;
      nxt_cnt = cnt_ff;
      if (sync2_ff != last_ff) begin
         nxt_cnt = CW'(1);
      end else if (cnt_ff < CMAX) begin
         nxt_cnt = cnt_ff + CW'(1);
      end
      if (sync2_ff == last_ff && cnt_ff >= CMAX - CW'(1)) begin
         nxt_stable = sync2_ff;
         nxt_valid = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         last_ff <= '0;
         stable_ff <= '0;
         cnt_ff <= '0;
         valid_ff <= 1'b0;
      end else begin
         sync1_ff <= pin;
         sync2_ff <= sync1_ff;
         last_ff <= sync2_ff;
         stable_ff <= nxt_stable;
         cnt_ff <= nxt_cnt;
         valid_ff <= nxt_valid;
      end
   end

   assign value = stable_ff;
   assign valid = valid_ff;
endmodule : input_debounce

// File: test/lane_peer_model.sv
// far side of the signal: lamp sensing, emitter health and a one-member interlock loop
// assumes lamp_drive and ilk_out come from the block on clk_sys
module lane_peer_model import lane_signal_pkg::*; (
   input wire logic clk_sys,
   input wire aspect_t lamp_drive,
   input wire ilk_out_t ilk_out,
   input wire logic [3:0] fail_mask,
   input wire logic [3:0] prim_bad,
   input wire logic health_ok,
   output logic [3:0] lamp_ok,
   output logic [3:0] primary_ok,
   output ilk_in_t ilk_in
);
   timeunit 1ns;
   timeprecision 1ns;
   initial lamp_ok = 4'h0;
   // sensed lit state lags the drive by one clock; a failed element never reads lit
   always @(posedge clk_sys) begin
      lamp_ok <= lamp_drive & ~fail_mask;
   end
   assign primary_ok = ~prim_bad;
   // head of chain tied high, chain end looped back to the only member
   assign ilk_in = '{perm: 2'b11, grp: ilk_out.perm, health: health_ok};
endmodule : lane_peer_model

// File: test/lane_signal_interlock_tb.sv
// self-checking bench for the lane signal interlock
// assumes the peer model closes the interlock loop for a single member
module lane_signal_interlock_tb import lane_signal_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   // code 6 asks for both arrows and both crosses
   localparam aspect_t [15:0] TB_MAP = {{9{4'h0}}, 4'hF, FACE_MAP_DEF[5:0]};
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] drive_code = 4'h0;
   logic [3:0] fail_mask = 4'h0;
   logic [3:0] prim_bad = 4'h0;
   logic ilk_bypass = 1'b0;
   logic health_ok = 1'b1;
   logic [3:0] lamp_ok, primary_ok, backup_sel, mon_code, lamp_fail;
   logic ilk_fault, ilk_latched;
   ilk_in_t ilk_in;
   ilk_out_t ilk_out;
   aspect_t lamp_drive, prev_ld;
   aspect_t exp_q[$];
   int num_errors = 0;
   int n_tests = 0;
   int seed = 70;
   logic saw_fault = 1'b0;

   always #25 clk_sys = ~clk_sys;

   lane_signal_interlock #(.FACE_MAP(TB_MAP), .DEB_CYCLES(2), .DEGRADE_CYCLES(40)) lane_signal_interlock_i (
      .clk_sys(clk_sys), .resetn(resetn), .drive_code(drive_code), .lamp_ok(lamp_ok),
      .primary_ok(primary_ok), .ilk_bypass(ilk_bypass), .ilk_in(ilk_in), .ilk_out(ilk_out),
      .lamp_drive(lamp_drive), .backup_sel(backup_sel), .mon_code(mon_code), .lamp_fail(lamp_fail),
      .ilk_fault(ilk_fault), .ilk_latched(ilk_latched));

   lane_peer_model lane_peer_model_i (
      .clk_sys(clk_sys), .lamp_drive(lamp_drive), .ilk_out(ilk_out), .fail_mask(fail_mask),
      .prim_bad(prim_bad), .health_ok(health_ok), .lamp_ok(lamp_ok), .primary_ok(primary_ok),
      .ilk_in(ilk_in));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      if (num_errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run

   // drive a code and note the lamp states it must step through
   task automatic set_code(input logic [3:0] c, input aspect_t e0, input aspect_t e1 = 4'h0);
      @(negedge clk_sys);
      exp_q.push_back(e0);
      if (e1 !== 4'h0) exp_q.push_back(e1);
      drive_code = c;
   endtask : set_code

   // bounded wait until every noted lamp state was seen, then let sensing settle
   task automatic settle();
      for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(negedge clk_sys);
      if (exp_q.size() > 0) begin
         check(8'h01, 8'h00);
         complete_run();
      end
      repeat (30) @(negedge clk_sys);
   endtask : settle

   // every lamp change must match the oldest note; an unnoted change is a mismatch
   always @(posedge clk_sys) begin
      if (resetn && lamp_drive !== prev_ld) begin
         if (exp_q.size() == 0) check({4'h0, lamp_drive}, 8'hEE);
         else check({4'h0, lamp_drive}, {4'h0, exp_q.pop_front()});
      end
      prev_ld <= lamp_drive;
   end

   // the fault flag and the echoed health line must both show a one-cycle drop
   always @(posedge clk_sys) begin
      if (ilk_fault === 1'b1 && ilk_out.health === 1'b0) saw_fault <= 1'b1;
   end

   initial begin
      repeat (10) @(negedge clk_sys);
      check({lamp_drive, mon_code}, 8'h0F);
      resetn = 1'b1;
      repeat (20) @(negedge clk_sys);
      check({4'h0, lamp_drive}, 8'h00);
      set_code(4'h1, 4'h1);
      settle();
      check({4'h0, mon_code}, 8'h01);
      prim_bad = 4'h1;
      repeat (60) @(negedge clk_sys);
      check({4'h0, backup_sel}, 8'h01);
      // cross lights at once, arrow waits for the own reverse cross to read lit
      set_code(4'h2, 4'h4, 4'h6);
      settle();
      check({4'h0, mon_code}, 8'h02);
      fail_mask = 4'h4;
      exp_q.push_back(4'h4);
      settle();
      check({lamp_fail, mon_code}, 8'h40);
      set_code(4'h0, 4'h0);
      settle();
      fail_mask = 4'h0;
      check({6'h0, ilk_out.perm}, 8'h00);
      ilk_bypass = 1'b1;
      repeat (30) @(negedge clk_sys);
      check({6'h0, ilk_out.perm}, 8'h03);
      ilk_bypass = 1'b0;
      set_code(4'h2, 4'h4, 4'h6);
      settle();
      // one-cycle drop of the health loop must be latched
      exp_q.push_back(4'h4);
      health_ok = 1'b0;
      @(negedge clk_sys);
      health_ok = 1'b1;
      settle();
      check({3'h0, ilk_fault, 3'h0, ilk_latched}, 8'h01);
      check({3'h0, saw_fault, 3'h0, ilk_out.health}, 8'h11);
      check({4'h0, lamp_fail}, 8'h00);
      set_code(4'h5, 4'h5);
      settle();
      check({3'h0, ilk_latched, mon_code}, 8'h05);
      set_code(4'h2, 4'h6);
      settle();
      // rearward arrow waits for the own forward cross; the cross lights at once
      set_code(4'h3, 4'h4);
      settle();
      set_code(4'h4, 4'h1, 4'h9);
      settle();
      check({4'h0, mon_code}, 8'h04);
      set_code(4'h6, 4'h5);
      settle();
      drive_code = 4'($random(seed));
      @(negedge clk_sys);
      drive_code = 4'h6;
      settle();
      check({4'h0, lamp_drive}, 8'h05);
      complete_run();
   end
endmodule : lane_signal_interlock_tb
